/* File: design/asf_device.sv */
// converter digital end: output framing, write port, sync, status and overrange
// How it works
// - serial clock is master clock halved
// - output frame low for 32 serial periods
// - drive on rise, host captures on fall
// - 24 data, five status, three zeros
// - settle bit low until filter settles
// - overrange also clears settle bit
// - low power bit reports low power mode
// - decimation bits, low bit one for 128
// - select bit makes next frame readback
// - host writes select eight periods early
// - strobe seen on fall, bits follow
// - strobe 1..32 periods, early refalls ignored
// - 16 address bits then 16 data
// - writes anytime, then settle cleared
// - sync low holds sequencer at zero
// - host holds sync low six clocks
// - sync release realigns output frame
// - overrange pin at quarter internal rate
// - per-word overrange bit, mirrored in status
// - overrange limit defaults to 80 percent
// - normal power at start, bit enters low
// - internal clock is master clock halved
// - reset sampled on rising clock edge
`timescale 1ns/100ps
module asf_device
   import asf_pkg::*;
(
   input  wire logic        clk,          // master clock
   input  wire logic        nrst,         // synchronous reset, low active
   asf_if.device            link,         // serial frame link
   input  wire logic        syncN,        // filter sync pin, low active
   input  wire logic        decSelect,    // decimation_select: 1 = 128x
   input  wire logic [23:0] sampleIn,     // filtered conversion value
   input  wire logic [15:0] stageLevel,   // first-stage magnitude
   output logic             overrangePin, // overrange alert
   output logic             lowPowerOut   // low power active
);
   typedef struct packed {
      logic        phase;      // internal clock phase, serial clock level
      logic [8:0]  seq;        // filter sequencer in internal cycles
      logic [5:0]  outBit;     // bits left in output frame
      logic [31:0] outSh;      // output shift register
      logic        output_frame_strobe_n;        // output frame strobe
      logic        serial_data_out;        // serial data
      logic        inActive;   // capturing write word
      logic [5:0]  inCnt;      // input bits taken
      logic [5:0]  ignCnt;     // strobe lockout periods left
      logic        fsiPrev;    // strobe at previous fall
      logic [31:0] inSh;       // input shift register
      logic [15:0] ctrl;       // control register
      logic [15:0] gain;       // gain register
      logic [15:0] ovrLim;     // overrange limit
      logic [7:0]  settleCnt;  // words until filter settled
      logic        settled;    // filter settled flag
      logic        ovrAcc;     // overrange seen this word
      logic        ovrWord;    // overrange of last word
      logic [1:0]  ovrDiv;     // quarter rate divider
      logic        ovrPin;     // alert pin
      logic        sync1;      // sync synchroniser stage 1
      logic        sync2;      // sync synchroniser stage 2
      logic        syncHeld;   // sequencer held in sync
      logic        fsi1;       // strobe sync stage 1
      logic        fsi2;       // strobe sync stage 2
      logic        sdi1;       // data sync stage 1
      logic        sdi2;       // data sync stage 2
      logic        dec1;       // decimation pin sync stage 1
      logic        dec2;       // decimation pin sync stage 2
   } asf_dev_t;
   asf_dev_t st_r, st_nxt;
   logic [8:0]  wordLen;
   logic [31:0] outWord;
   logic [4:0]  statBits;
   logic        rise, fall;
   always_comb begin
      // word period follows the decimation select
      wordLen  = st_r.dec2 ? 9'(DEC_LOW - 1) : 9'(DEC_HIGH - 1);
      // status register view: overrange is the mirror of the last word
      statBits = {st_r.settled, st_r.ovrWord, st_r.ctrl[CTRL_LOW_POWER_FLAG_BIT], 1'b0, st_r.dec2};
   end
   // pins pass two flops; sync sampled each clock stands in for the falling-edge poll
   always_comb begin
      st_nxt       = st_r;
      st_nxt.sync1 = syncN;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.fsi1  = link.inputFrameStrobeN;
      st_nxt.fsi2  = st_r.fsi1;
      st_nxt.sdi1  = link.serialDataIn;
      st_nxt.sdi2  = st_r.sdi1;
      st_nxt.dec1  = decSelect;
      st_nxt.dec2  = st_r.dec1;
      outWord      = 32'h0000_0000;
      st_nxt.phase = ~st_r.phase;
      rise = ~st_r.phase;                                          // serial clock goes high next
      fall = st_r.phase;
      // sync hold keeps sequencer at zero and restarts settling
      if (!st_r.sync2) begin
         // serial clock keeps running; the held sequencer realigns the next frame
         st_nxt.seq       = '0;
         st_nxt.syncHeld  = 1'b1;
         st_nxt.settled   = 1'b0;
         st_nxt.settleCnt = 8'(SETTLE_WORDS);
         st_nxt.output_frame_strobe_n       = 1'b1;
         st_nxt.outBit    = '0;
      end else if (fall) begin
         st_nxt.syncHeld = 1'b0;
         st_nxt.seq = (st_r.seq >= wordLen) ? '0 : st_r.seq + 9'd1;
         // overrange pin refreshes every fourth internal cycle
         st_nxt.ovrDiv = st_r.ovrDiv + 2'd1;
         if (st_r.ovrDiv == 2'(OVR_DIV - 1))
            st_nxt.ovrPin = (stageLevel > st_r.ovrLim);
         if (stageLevel > st_r.ovrLim) begin
            st_nxt.ovrAcc  = 1'b1;
            st_nxt.settled = 1'b0;
         end
      end
      // frame start at word boundary, on a rising serial edge
      if (st_r.sync2 && rise && st_r.seq == 9'd0) begin
         st_nxt.ovrWord = st_r.ovrAcc;
         st_nxt.ovrAcc  = 1'b0;
         if (st_r.settleCnt != 8'd0)
            st_nxt.settleCnt = st_r.settleCnt - 8'd1;
         else if (!st_r.ovrAcc)
            st_nxt.settled = 1'b1;
         if (st_r.ctrl[CTRL_RD_STAT])
            outWord = {16'h0000, 8'h00, statBits, 3'b000};
         else if (st_r.ctrl[CTRL_RD_OVRNG])
            outWord = {st_r.ovrLim, 16'h0000};
         else if (st_r.ctrl[CTRL_RD_GAIN])
            outWord = {st_r.gain, 16'h0000};
         // a result carries the overrange of its own gathering period
         else
            outWord = {sampleIn, st_r.settled, st_r.ovrAcc, statBits[2:0], 3'b000};
         st_nxt.ctrl[CTRL_RD_GAIN:CTRL_RD_STAT] = 3'b000;
         st_nxt.outBit = 6'(WORD_BITS);
         st_nxt.output_frame_strobe_n    = 1'b0;
         // msb leaves with the strobe so the host's first fall already sees it
         st_nxt.serial_data_out    = outWord[31];
         st_nxt.outSh  = {outWord[30:0], 1'b0};
      end else if (st_r.sync2 && rise && st_r.outBit != 6'd0) begin
         // one bit per later rising serial edge; a sync cuts the frame short
         st_nxt.outBit = st_r.outBit - 6'd1;
         if (st_r.outBit == 6'd1) begin
            st_nxt.output_frame_strobe_n = 1'b1;
         end else begin
            st_nxt.serial_data_out   = st_r.outSh[31];
            st_nxt.outSh = {st_r.outSh[30:0], 1'b0};
         end
      end
      if (fall) begin
         // write port: strobe checked on serial falls, lockout for 32 periods
         st_nxt.fsiPrev = st_r.fsi2;
         if (st_r.ignCnt != 6'd0)
            st_nxt.ignCnt = st_r.ignCnt - 6'd1;
         if (st_r.inActive) begin
            st_nxt.inSh  = {st_r.inSh[30:0], st_r.sdi2};
            st_nxt.inCnt = st_r.inCnt + 6'd1;
            if (st_r.inCnt == 6'(WORD_BITS - 1)) begin
               st_nxt.inActive = 1'b0;
               // first half is address, second half data
               if (st_r.inSh[30:15] == ADDR_CTRL)
                  st_nxt.ctrl = {st_r.inSh[14:0], st_r.sdi2};
               else if (st_r.inSh[30:15] == ADDR_GAIN)
                  st_nxt.gain = {st_r.inSh[14:0], st_r.sdi2};
               else if (st_r.inSh[30:15] == ADDR_OVRNG)
                  st_nxt.ovrLim = {st_r.inSh[14:0], st_r.sdi2};
               st_nxt.settled   = 1'b0;
               st_nxt.settleCnt = 8'(SETTLE_WORDS);
            end
         end else if (!st_r.fsi2 && st_r.fsiPrev && st_r.ignCnt == 6'd0) begin
            st_nxt.inActive = 1'b1;
            st_nxt.inCnt    = '0;
            st_nxt.ignCnt   = 6'(WORD_BITS);
         end
      end
   end
   // reset taken on rising edge of master clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '{phase: 1'b0, seq: 9'h000, outBit: 6'h00, outSh: 32'h0000_0000, output_frame_strobe_n: 1'b1,
                  serial_data_out: 1'b0, inActive: 1'b0, inCnt: 6'h00, ignCnt: 6'h00, fsiPrev: 1'b1,
                  inSh: 32'h0000_0000, ctrl: 16'h0000, gain: GAIN_RST, ovrLim: OVRNG_RST,
                  settleCnt: 8'(SETTLE_WORDS), settled: 1'b0, ovrAcc: 1'b0, ovrWord: 1'b0,
                  ovrDiv: 2'b00, ovrPin: 1'b0, sync1: 1'b1, sync2: 1'b1, syncHeld: 1'b0,
                  fsi1: 1'b1, fsi2: 1'b1, sdi1: 1'b0, sdi2: 1'b0,
                  dec1: decSelect, dec2: st_r.dec1};   // strap keeps syncing so frame one reports it
      end else begin
         st_r <= st_nxt;
      end
   end
   // outputs come straight from state flops
   assign link.serialClockOut     = st_r.phase;
   assign link.outputFrameStrobeN = st_r.output_frame_strobe_n;
   assign link.serialDataOut      = st_r.serial_data_out;
   assign overrangePin            = st_r.ovrPin;
   assign lowPowerOut             = st_r.ctrl[CTRL_LOW_POWER_FLAG_BIT];
endmodule

/* File: inc/asf_pkg.sv */
// shared constants and types for the converter serial frame link
package asf_pkg;
   localparam int WORD_BITS       = 32;            // bits per output and input word
   localparam int DATA_BITS       = 24;            // conversion bits per word
   localparam int ADDR_BITS       = 16;            // address half of a write
   localparam int SETUP_SCO       = 8;             // readback select lead, serial periods
   localparam int DEC_LOW         = 128;           // decimation when select is high
   localparam int DEC_HIGH        = 256;           // decimation when select is low
   localparam int SETTLE_WORDS    = 4;             // filter settle time in output words
   localparam int OVR_DIV         = 4;             // overrange pin update divider (icycles)
   // register addresses on the write link
   localparam logic [15:0] ADDR_CTRL   = 16'h0001;
   localparam logic [15:0] ADDR_STATUS = 16'h0002;
   localparam logic [15:0] ADDR_GAIN   = 16'h0004;
   localparam logic [15:0] ADDR_OVRNG  = 16'h0005;
   // control register fields
   localparam int CTRL_LOW_POWER_FLAG_BIT   = 0;
   localparam int CTRL_RD_STAT    = 4;
   localparam int CTRL_RD_OVRNG   = 5;
   localparam int CTRL_RD_GAIN    = 6;
   localparam logic [15:0] GAIN_RST  = 16'hA000;   // gain reset value
   localparam logic [15:0] OVRNG_RST = 16'hCCCC;   // 80 percent of full scale
   // status bit positions inside the 32-bit word
   localparam int ST_SETTLE = 7;
   localparam int ST_OVR    = 6;
   localparam int ST_LOW_POWER_FLAG   = 5;
   localparam int ST_DEC1   = 4;
   localparam int ST_DEC0   = 3;
   // avalon register offsets of the host controller
   localparam logic [3:0] AV_CMD    = 4'h0;        // write: addr hi, data lo; launches write
   localparam logic [3:0] AV_RDATA  = 4'h4;        // last received word
   localparam logic [3:0] AV_STATUS = 4'h8;        // bit0 busy, bit1 new word sticky
   localparam logic [3:0] AV_SAMPLE = 4'hC;        // device side sample in
   localparam int HOST_CYC = 3;                    // host cycles per serial period min
endpackage

/* File: inc/asf_if.sv */
// serial frame link between converter device and host controller
`timescale 1ns/100ps
interface asf_if;
   logic serialClockOut;       // serial clock from device
   logic outputFrameStrobeN;   // output frame, low for 32 periods
   logic serialDataOut;        // device to host data
   logic inputFrameStrobeN;    // host write frame strobe
   logic serialDataIn;         // host to device data
   modport device (output serialClockOut, output outputFrameStrobeN, output serialDataOut,
                   input inputFrameStrobeN, input serialDataIn);
   modport host   (input serialClockOut, input outputFrameStrobeN, input serialDataOut,
                   output inputFrameStrobeN, output serialDataIn);
endinterface

/* File: design/asf_host.sv */
// host controller end: avalon slave that receives frames and sends writes
`timescale 1ns/100ps
module asf_host
   import asf_pkg::*;
(
   input  wire logic        clk,           // system clock
   input  wire logic        nrst,          // synchronous reset, low active
   asf_if.host              link,          // serial frame link
   input  wire logic [3:0]  address,       // avalon byte address
   input  wire logic        read,          // avalon read
   input  wire logic        write,         // avalon write
   input  wire logic [31:0] writedata,     // avalon write data
   output logic [31:0]      readdata,      // avalon read data
   output logic             waitrequest    // avalon stall
);
   typedef struct packed {
      logic        sco1, sco2, scoPrev;   // serial clock sync and edge
      logic        fso1, fso2;            // frame sync
      logic        sdo1, sdo2;            // data sync
      logic        rxOn;                  // receiving a frame
      logic [5:0]  rxCnt;                 // bits received
      logic [31:0] rxSh;                  // receive shift
      logic [31:0] rxWord;                // last full word
      logic        rxNew;                 // sticky new-word flag
      logic        txOn;                  // sending a write
      logic [5:0]  txCnt;                 // bits left to send
      logic [31:0] txSh;                  // transmit shift
      logic        input_frame_strobe_n;                   // input frame strobe
      logic        serial_data_in;                   // input data
      logic        ack;                   // bus answer cycle
      logic [31:0] rdata;                 // bus read data
      logic        wreq;                  // waitrequest, low only in the answer cycle
   } asf_host_t;
   asf_host_t st_r, st_nxt;
   logic scoFall, scoRise, busy;
   always_comb begin
      st_nxt      = st_r;
      st_nxt.sco1 = link.serialClockOut;
      st_nxt.sco2 = st_r.sco1;
      st_nxt.scoPrev = st_r.sco2;
      st_nxt.fso1 = link.outputFrameStrobeN;
      st_nxt.fso2 = st_r.fso1;
      st_nxt.sdo1 = link.serialDataOut;
      st_nxt.sdo2 = st_r.sdo1;
      scoFall = st_r.scoPrev & ~st_r.sco2;
      scoRise = ~st_r.scoPrev & st_r.sco2;
      busy    = st_r.txOn;
      st_nxt.ack = 1'b0;
      st_nxt.wreq = 1'b1;
      // capture device data on falling serial edges while frame is low
      if (scoFall && !st_r.fso2) begin
         st_nxt.rxSh  = {st_r.rxSh[30:0], st_r.sdo2};
         st_nxt.rxCnt = st_r.rxCnt + 6'd1;
         if (st_r.rxCnt == 6'(WORD_BITS - 1)) begin
            st_nxt.rxWord = {st_r.rxSh[30:0], st_r.sdo2};
            st_nxt.rxNew  = 1'b1;                                 // set wins over clear below
            st_nxt.rxCnt  = '0;
         end
      end
      if (st_r.fso2)
         st_nxt.rxCnt = '0;
      // drive write bits on rising edges so device samples on falls
      if (scoRise && st_r.txOn) begin
         if (st_r.txCnt == 6'd0) begin
            st_nxt.txOn = 1'b0;
            st_nxt.input_frame_strobe_n  = 1'b1;
         end else begin
            st_nxt.input_frame_strobe_n   = (st_r.txCnt > 6'(WORD_BITS - 1)) ? 1'b0 : 1'b1;  // low two periods
            st_nxt.serial_data_in   = st_r.txSh[31];
            if (st_r.txCnt <= 6'(WORD_BITS))
               st_nxt.txSh = (st_r.txCnt == 6'(WORD_BITS + 1)) ? st_r.txSh : {st_r.txSh[30:0], 1'b0};
            st_nxt.txCnt = st_r.txCnt - 6'd1;
         end
      end
      // avalon slave: one-cycle wait then answer
      if ((read || write) && !st_r.ack) begin
         st_nxt.ack = 1'b1;
         st_nxt.wreq = 1'b0;
         if (write && address == AV_CMD && !busy) begin
            st_nxt.txSh  = writedata;
            st_nxt.txCnt = 6'(WORD_BITS + 1);
            st_nxt.txOn  = 1'b1;
         end
         if (read) begin
            if (address == AV_RDATA)
               st_nxt.rdata = st_r.rxWord;
            else if (address == AV_STATUS)
               st_nxt.rdata = {30'h0, st_r.rxNew, busy};
            else
               st_nxt.rdata = 32'h0000_0000;
            if (address == AV_RDATA && !(scoFall && st_r.rxCnt == 6'(WORD_BITS - 1)))
               st_nxt.rxNew = 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '{sco1: 1'b0, sco2: 1'b0, scoPrev: 1'b0, fso1: 1'b1, fso2: 1'b1, sdo1: 1'b0,
                  sdo2: 1'b0, rxOn: 1'b0, rxCnt: 6'h00, rxSh: 32'h0000_0000, rxWord: 32'h0000_0000,
                  rxNew: 1'b0, txOn: 1'b0, txCnt: 6'h00, txSh: 32'h0000_0000, input_frame_strobe_n: 1'b1, serial_data_in: 1'b0,
                  ack: 1'b0, rdata: 32'h0000_0000, wreq: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign link.inputFrameStrobeN = st_r.input_frame_strobe_n;
   assign link.serialDataIn      = st_r.serial_data_in;
   assign readdata               = st_r.rdata;
   assign waitrequest            = st_r.wreq;
endmodule

/* File: dv/asf_link_sva.sv */
// checker for serial frame timing on the shared link
`timescale 1ns/100ps
module asf_link_sva (
   input wire logic clk,                // master clock
   input wire logic nrst,               // sync reset, low active
   input wire logic serialClockOut,     // serial clock
   input wire logic outputFrameStrobeN, // output frame strobe
   input wire logic serialDataOut,      // device data
   input wire logic inputFrameStrobeN,  // write frame strobe
   input wire logic serialDataIn        // host data
);
   typedef struct packed {
      logic [6:0] lowCnt;   // clk cycles with frame low
      logic [5:0] bitCnt;   // serial rises inside frame
      logic       scoPrev;  // serial clock one edge ago
      logic       fsiPrev;  // write strobe one edge ago
      logic [7:0] sinceFsi; // clk cycles since write strobe fell
   } asf_chk_t;
   asf_chk_t st_r;
   asf_chk_t st_nxt;

   // counters saturate so a stuck strobe cannot wrap into a false pass
   always_comb begin
      st_nxt = st_r;
      st_nxt.scoPrev = serialClockOut;
      st_nxt.fsiPrev = inputFrameStrobeN;
      if (outputFrameStrobeN) begin
         st_nxt.lowCnt = 7'h00;
         st_nxt.bitCnt = 6'h00;
      end else begin
         if (st_r.lowCnt != 7'h7F) st_nxt.lowCnt = st_r.lowCnt + 7'h01;
         if (serialClockOut && !st_r.scoPrev && st_r.bitCnt != 6'h3F) st_nxt.bitCnt = st_r.bitCnt + 6'h01;
      end
      if (!inputFrameStrobeN && st_r.fsiPrev) st_nxt.sinceFsi = 8'h00;
      else if (st_r.sinceFsi != 8'hFF) st_nxt.sinceFsi = st_r.sinceFsi + 8'h01;
   end

   // helper state register
   always_ff @(posedge clk) begin
      if (!nrst) st_r <= '{7'h00, 6'h00, 1'b0, 1'b1, 8'hFF};
      else st_r <= st_nxt;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_sco_half_rate: assert property ($past(nrst) |-> serialClockOut != $past(serialClockOut))
      else $error("serial clock did not toggle");
   a_frame_len: assert property ($rose(outputFrameStrobeN) |-> st_r.lowCnt == 7'h40)
      else $error("output frame not 64 clocks long");
   a_frame_bits: assert property ($rose(outputFrameStrobeN) |-> st_r.bitCnt == 6'h20)
      else $error("output frame not 32 serial periods");
   a_frame_start_rise: assert property ($fell(outputFrameStrobeN) |-> $rose(serialClockOut))
      else $error("frame started off a rising serial edge");
   a_data_on_rise: assert property (!$stable(serialDataOut) |-> $rose(serialClockOut))
      else $error("output data changed off a rising serial edge");
   a_bit_hold: assert property ($rose(serialClockOut) |=> $stable(serialDataOut))
      else $error("output bit not held one serial period");
   a_tail_zero: assert property (!outputFrameStrobeN && serialClockOut && !st_r.scoPrev && st_r.bitCnt >= 6'h1D
      |-> !serialDataOut)
      else $error("trailing bit not zero");
   a_fsi_width: assert property ($fell(inputFrameStrobeN) |-> ##[1:64] inputFrameStrobeN)
      else $error("write strobe low too long");
   a_fsi_spacing: assert property ($fell(inputFrameStrobeN) |-> st_r.sinceFsi >= 8'h42)
      else $error("write strobe fell inside a write");

   c_frame: cover property ($rose(outputFrameStrobeN));
   c_write: cover property ($fell(inputFrameStrobeN) ##2 serialDataIn);
   c_high_bit: cover property (!outputFrameStrobeN && serialDataOut);
endmodule

/* File: dv/testbench.sv */
// bench: device and host ends joined, driven over avalon and device pins
`timescale 1ns/100ps
module testbench import asf_pkg::*;;
   logic        clk;
   logic        nrst;
   logic        syncN;
   logic        decSelect;
   logic [23:0] sampleIn;
   logic [15:0] stageLevel;
   logic        overrangePin;
   logic        lowPowerOut;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic        waitrequest;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic [31:0] w;
   logic [15:0] rbSel [4] = '{16'h0021, 16'h0041, 16'h0021, 16'h0011};
   // status readback: not settled, no overrange, low power, 128x
   logic [31:0] rbExp [4] = '{{OVRNG_RST, 16'h0000}, {GAIN_RST, 16'h0000}, 32'h8421_0000,
                              {24'h000000, 5'b00101, 3'b000}};
   int          fails = 0;
   int          tests_run = 0;
   int          cycles = 0;

   asf_if link_if ();
   asf_device u_asf_device (.clk(clk), .nrst(nrst), .link(link_if), .syncN(syncN), .decSelect(decSelect),
      .sampleIn(sampleIn), .stageLevel(stageLevel), .overrangePin(overrangePin), .lowPowerOut(lowPowerOut));
   asf_host u_asf_host (.clk(clk), .nrst(nrst), .link(link_if), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   asf_link_sva u_asf_link_sva (.clk(clk), .nrst(nrst), .serialClockOut(link_if.serialClockOut),
      .outputFrameStrobeN(link_if.outputFrameStrobeN), .serialDataOut(link_if.serialDataOut),
      .inputFrameStrobeN(link_if.inputFrameStrobeN), .serialDataIn(link_if.serialDataIn));

   // 100 MHz master clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard, well above the roughly 8100 cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one avalon transfer; request held until waitrequest is sampled low
   task automatic av_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic poll(input int bitN, input logic val);
      logic [31:0] s;
      do av_cycle(1'b0, AV_STATUS, 32'h0, s); while (s[bitN] !== val);
   endtask

   // drop any stale word, then fetch the next one received
   task automatic next_word(output logic [31:0] q);
      av_cycle(1'b0, AV_RDATA, 32'h0, q);
      poll(1, 1'b1);
      av_cycle(1'b0, AV_RDATA, 32'h0, q);
   endtask

   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] q;
      av_cycle(1'b1, AV_CMD, {a, d}, q);
      poll(0, 1'b0);
      // busy drops before the device's two-flop input pipe has landed the last bit
      repeat (4) @(posedge clk);
   endtask

   // status field order: settle, overrange, low power, zero, decimation
   function automatic logic [31:0] word(input logic [4:0] s);
      return {sampleIn, s, 3'h0};
   endfunction

   // main sequence
   initial begin
      nrst = 1'b0;
      syncN = 1'b1;
      decSelect = 1'b1;
      sampleIn = 24'h5A3C96;
      stageLevel = 16'h0100;
      address = AV_CMD;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      next_word(w);
      chk("first word", word(5'h01), w);
      chk("normal power", 32'h0, {31'h0, lowPowerOut});
      repeat (6) next_word(w);
      chk("settled word", word(5'h11), w);
      stageLevel <= 16'hFFFF;
      repeat (40) @(posedge clk);
      chk("pin high", 32'h1, {31'h0, overrangePin});
      repeat (2) next_word(w);
      chk("overrange word", word(5'h09), w);
      stageLevel <= 16'h0100;
      repeat (40) @(posedge clk);
      chk("pin low", 32'h0, {31'h0, overrangePin});
      repeat (2) next_word(w);
      chk("overrange cleared", word(5'h01), w & 32'hFFFFFF7F);
      reg_write(ADDR_CTRL, 16'h0001);
      chk("low power pin", 32'h1, {31'h0, lowPowerOut});
      repeat (2) next_word(w);
      chk("low power word", word(5'h05), w);
      foreach (rbSel[i]) begin
         if (i == 2) reg_write(ADDR_OVRNG, 16'h8421);
         next_word(w);
         reg_write(ADDR_CTRL, rbSel[i]);
         next_word(w);
         chk("readback", rbExp[i], w);
      end
      next_word(w);
      chk("data after readback", {sampleIn, 8'h0}, w & 32'hFFFFFF00);
      decSelect <= 1'b0;
      repeat (5) next_word(w);
      chk("decimation low", 32'hA0, w & 32'hFF);
      syncN <= 1'b0;
      repeat (6) @(posedge clk);
      syncN <= 1'b1;
      next_word(w);
      chk("settle after sync", 32'h0, {31'h0, w[7]});
      complete_run();
   end
endmodule
